/* synth_cfg_pkg.sv */
// Shared constants for the synthesizer configuration logic and its clock divider.
package synth_cfg_pkg;
  // Field widths and positions inside the serial shift register.
  localparam int FB_WIDTH = 9;
  localparam int OUT_CODE_WIDTH = 2;
  localparam int OBS_WIDTH = 2;
  localparam int SHIFT_WIDTH = 13;
  localparam int FB_LSB = 0;
  localparam int OUT_CODE_LSB = 9;
  localparam int OBS_LSB = 11;
  // Output divide ratio is the code plus this base.
  localparam logic [2:0] OUT_RATIO_BASE = 3'h3;
  // Observe output selections.
  localparam logic [1:0] OBS_LOW = 2'h0;
  localparam logic [1:0] OBS_SDATA = 2'h1;
  localparam logic [1:0] OBS_FEEDBACK = 2'h2;
  localparam logic [1:0] OBS_FOUT = 2'h3;
  // Feedback values that lock with a 25 MHz reference.
  localparam logic [8:0] LOCK_FB_MIN = 9'h019;
  localparam logic [8:0] LOCK_FB_MAX = 9'h01F;
  // Reset values of the loaded configuration.
  localparam logic [8:0] FB_RESET = 9'h000;
  localparam logic [1:0] OUT_CODE_RESET = 2'h0;
  localparam logic [1:0] OBS_RESET = 2'h0;
  localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET = 13'h0000;
  // Register map, byte addresses.
  localparam int ADDR_WIDTH = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // Control and status fields.
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int STAT_FB_LSB = 0;
  localparam int STAT_OUT_CODE_LSB = 9;
  localparam int STAT_OBS_LSB = 11;
  localparam int STAT_SERIAL_MODE_BIT = 13;
  localparam int STAT_LOCK_RANGE_BIT = 14;
  localparam int STAT_RESET_BIT = 15;
endpackage : synth_cfg_pkg

`timescale 1ns/1ns
// Divides a sampled clock level by a programmable ratio with an even duty.
module toggle_divider
  import synth_cfg_pkg::*;
#(
  parameter int DIV_WIDTH = 9
)
(
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Control.
  input wire logic clear,
  input wire logic [DIV_WIDTH-1:0] divisor,
  // Source and result.
  input wire logic src_in,
  output logic div_out
);
  logic src_q;
  logic [DIV_WIDTH-1:0] count_q;
  logic src_edge;

  if (DIV_WIDTH < 2)
  begin : g_width_check
    $error("toggle_divider needs a divisor at least two bits wide.");
  end

  // Counting both edges of the source and toggling every divisor edges keeps the duty at half for odd ratios too.
  assign src_edge = src_in ^ src_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      src_q <= 1'b0;
      count_q <= '0;
      div_out <= 1'b0;
    end
    else if (ce)
    begin
      src_q <= src_in;
      if (clear)
      begin
        count_q <= '0;
        div_out <= 1'b0;
      end
      else if (src_edge)
      begin
        if (count_q + 1'b1 >= divisor)
        begin
          count_q <= '0;
          div_out <= ~div_out;
        end
        else
        begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
endmodule : toggle_divider

/* synth_divider_config_logic.sv */
// Configuration, divider control and register slave of the frequency synthesizer.
// Operation
// - Master reset clears dividers, forces clock outputs low.
// - Master reset keeps loaded divide and observe values.
// - Serial mode shifts data on serial clock rise.
// - Reference select high picks crystal, low alternate.
// - Bypass select picks PLL or bypass mode.
// - Latch input low passes pins, observe low.
// - Latch rise captures pins until next change.
// - Serial load rise with serial clock low moves shift register out.
// - Serial load fall freezes current divide values.
// - Serial load held high: dividers follow shifting.
// - Feedback divide is plain nine-bit binary.
// - Output code selects ratio three to six.
// - Each enable input drives or floats one output.
// - Observe bits pick low, data, feedback, output.
// - Output divider gives even duty at every ratio.
`timescale 1ns/1ns
module synth_divider_config_logic
  import synth_cfg_pkg::*;
(
  // Clock, reset and enable.
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  // APB register slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_WIDTH-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Divider control pins.
  input wire logic DIVIDER_MASTER_RESET,
  input wire logic PARALLEL_LATCH_N,
  input wire logic [FB_WIDTH-1:0] FEEDBACK_DIVIDE_PINS,
  input wire logic [OUT_CODE_WIDTH-1:0] OUTPUT_DIVIDE_PINS,
  // Serial programming pins.
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA,
  input wire logic SERIAL_LOAD,
  // Reference and mode pins.
  input wire logic REFERENCE_SOURCE_SELECT,
  input wire logic CRYSTAL_INPUT,
  input wire logic ALTERNATE_REFERENCE,
  input wire logic PLL_BYPASS_SELECT,
  input wire logic VCO_CLOCK,
  // Toward the analog loop.
  output logic CRYSTAL_DRIVE,
  output logic PLL_REFERENCE,
  output logic [FB_WIDTH-1:0] FEEDBACK_VALUE,
  output logic FEEDBACK_CLOCK,
  // Clock outputs with enables.
  input wire logic OUTPUT_ZERO_ENABLE,
  input wire logic OUTPUT_ONE_ENABLE,
  output logic CLOCK_OUT_ZERO,
  output logic CLOCK_OUT_ZERO_OE,
  output logic CLOCK_OUT_ONE,
  output logic CLOCK_OUT_ONE_OE,
  output logic OBSERVE_OUT
);
  logic [SHIFT_WIDTH-1:0] shift_q;
  logic [SHIFT_WIDTH-1:0] shift_d;
  logic [FB_WIDTH-1:0] fb_q;
  logic [OUT_CODE_WIDTH-1:0] out_code_q;
  logic [OBS_WIDTH-1:0] obs_q;
  logic latch_prev_q;
  logic load_prev_q;
  logic sclk_prev_q;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic mr;
  logic serial_mode;
  logic latch_rise;
  logic load_rise;
  logic sclk_rise;
  logic shift_en;
  logic [FB_WIDTH-1:0] fb_eff;
  logic [OUT_CODE_WIDTH-1:0] out_code_eff;
  logic [FB_WIDTH-1:0] out_ratio;
  logic ref_clk;
  logic div_src;
  logic fout;
  logic fb_div;
  logic observe_d;
  logic [31:0] rdata;
  logic mapped;
  logic setup_phase;
  logic access_phase;

  // Software reset joins the pin so a stuck board strap can still be overridden.
  assign mr = DIVIDER_MASTER_RESET | ctrl_q[CTRL_SOFT_RESET_BIT];
  assign serial_mode = PARALLEL_LATCH_N;
  assign latch_rise = PARALLEL_LATCH_N & ~latch_prev_q;
  assign load_rise = SERIAL_LOAD & ~load_prev_q;
  assign sclk_rise = SERIAL_CLOCK & ~sclk_prev_q;
  assign shift_en = !mr && serial_mode && sclk_rise;
  assign shift_d = {shift_q[SHIFT_WIDTH-2:0], SERIAL_DATA};

  // Edge history of the programming pins.
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      latch_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end
    else if (CE)
    begin
      latch_prev_q <= PARALLEL_LATCH_N;
      load_prev_q <= SERIAL_LOAD;
      sclk_prev_q <= SERIAL_CLOCK;
    end
  end

  // Serial shift register, most significant field first.
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      shift_q <= SHIFT_RESET;
    end
    else if (CE && shift_en)
    begin
      shift_q <= shift_d;
    end
  end

  // Loaded divide and observe values; updates are held off while the dividers sit in reset.
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fb_q <= FB_RESET;
      out_code_q <= OUT_CODE_RESET;
      obs_q <= OBS_RESET;
    end
    else if (CE && !mr)
    begin
      if (!serial_mode || latch_rise)
      begin
        fb_q <= FEEDBACK_DIVIDE_PINS;
        out_code_q <= OUTPUT_DIVIDE_PINS;
      end
      else if (SERIAL_LOAD && sclk_rise)
      begin
        fb_q <= shift_d[FB_LSB +: FB_WIDTH];
        out_code_q <= shift_d[OUT_CODE_LSB +: OUT_CODE_WIDTH];
        obs_q <= shift_d[OBS_LSB +: OBS_WIDTH];
      end
      else if (load_rise && !SERIAL_CLOCK)
      begin
        fb_q <= shift_q[FB_LSB +: FB_WIDTH];
        out_code_q <= shift_q[OUT_CODE_LSB +: OUT_CODE_WIDTH];
        obs_q <= shift_q[OBS_LSB +: OBS_WIDTH];
      end
      // A falling serial load leaves the values where they are, so later shifting cannot reach them.
    end
  end

  // Parallel mode feeds the pins straight through; otherwise the held values apply.
  assign fb_eff = serial_mode ? fb_q : FEEDBACK_DIVIDE_PINS;
  assign out_code_eff = serial_mode ? out_code_q : OUTPUT_DIVIDE_PINS;
  assign out_ratio = FB_WIDTH'({1'b0, out_code_eff} + OUT_RATIO_BASE);

  // Reference and bypass selection.
  assign ref_clk = REFERENCE_SOURCE_SELECT ? CRYSTAL_INPUT : ALTERNATE_REFERENCE;
  assign div_src = PLL_BYPASS_SELECT ? VCO_CLOCK : ref_clk;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PLL_REFERENCE <= 1'b0;
      CRYSTAL_DRIVE <= 1'b1;
      FEEDBACK_VALUE <= FB_RESET;
    end
    else if (CE)
    begin
      PLL_REFERENCE <= ref_clk;
      CRYSTAL_DRIVE <= ~CRYSTAL_INPUT;
      FEEDBACK_VALUE <= fb_eff;
    end
  end

  // Output divider shared by both clock outputs.
  toggle_divider #(
    .DIV_WIDTH(FB_WIDTH)
  ) u_out_div (
    .clk_sys(CLK_SYS),
    .rstn(RSTN),
    .ce(CE),
    .clear(mr),
    .divisor(out_ratio),
    .src_in(div_src),
    .div_out(fout)
  );

  // Feedback divider, only meaningful while the loop runs.
  toggle_divider #(
    .DIV_WIDTH(FB_WIDTH)
  ) u_fb_div (
    .clk_sys(CLK_SYS),
    .rstn(RSTN),
    .ce(CE),
    .clear(mr),
    .divisor(fb_eff),
    .src_in(VCO_CLOCK),
    .div_out(fb_div)
  );

  assign CLOCK_OUT_ZERO = fout;
  assign CLOCK_OUT_ONE = fout;
  assign FEEDBACK_CLOCK = fb_div;
  assign CLOCK_OUT_ZERO_OE = OUTPUT_ZERO_ENABLE;
  assign CLOCK_OUT_ONE_OE = OUTPUT_ONE_ENABLE;

  // Observe output; forced low outside serial mode.
  always_comb
  begin
    observe_d = 1'b0;
    if (serial_mode)
    begin
      unique case (obs_q)
        OBS_LOW: observe_d = 1'b0;
        OBS_SDATA: observe_d = SERIAL_DATA;
        OBS_FEEDBACK: observe_d = fb_div;
        OBS_FOUT: observe_d = fout;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      OBSERVE_OUT <= 1'b0;
    end
    else if (CE)
    begin
      OBSERVE_OUT <= observe_d;
    end
  end

  // APB slave: read data is captured in the setup cycle so it leaves a flip-flop.
  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE && CE;
  assign mapped = (PADDR == CTRL_OFFSET) || (PADDR == STATUS_OFFSET);
  assign PREADY = CE;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_q;

  always_comb
  begin
    rdata = 32'h00000000;
    if (PADDR == CTRL_OFFSET)
    begin
      rdata = ctrl_q;
    end
    else if (PADDR == STATUS_OFFSET)
    begin
      rdata[STAT_FB_LSB +: FB_WIDTH] = fb_eff;
      rdata[STAT_OUT_CODE_LSB +: OUT_CODE_WIDTH] = out_code_eff;
      rdata[STAT_OBS_LSB +: OBS_WIDTH] = obs_q;
      rdata[STAT_SERIAL_MODE_BIT] = serial_mode;
      rdata[STAT_LOCK_RANGE_BIT] = (fb_eff >= LOCK_FB_MIN) && (fb_eff <= LOCK_FB_MAX);
      rdata[STAT_RESET_BIT] = mr;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (CE && setup_phase)
    begin
      prdata_q <= PWRITE ? 32'h00000000 : rdata;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (access_phase && PWRITE && PADDR == CTRL_OFFSET)
    begin
      ctrl_q <= {31'h00000000, PWDATA[CTRL_SOFT_RESET_BIT]};
    end
  end

  // Checks kept beside the logic.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  sequence s_serial_idle;
    CE && !mr && serial_mode && latch_prev_q;
  endsequence

  sequence s_load_rise;
    s_serial_idle ##0 load_rise && !SERIAL_CLOCK && !sclk_rise;
  endsequence

  a_reset_clears_out: assert property (CE && mr |=> !CLOCK_OUT_ZERO && !CLOCK_OUT_ONE && !FEEDBACK_CLOCK)
    else $error("Clock outputs not low after master reset.");

  a_reset_keeps_values: assert property (mr |=> fb_q == $past(fb_q) && obs_q == $past(obs_q))
    else $error("Loaded values changed under master reset.");

  a_serial_shift_in: assert property (CE && shift_en |=> shift_q == {$past(shift_q[SHIFT_WIDTH-2:0]), $past(SERIAL_DATA)})
    else $error("Shift register did not take the serial data bit.");

  a_parallel_pass: assert property (CE && !mr && !serial_mode |=> !OBSERVE_OUT ##0 FEEDBACK_VALUE == $past(FEEDBACK_DIVIDE_PINS))
    else $error("Parallel pins not passed through or observe not low.");

  a_parallel_latch: assert property (CE && !mr && latch_rise |=> fb_q == $past(FEEDBACK_DIVIDE_PINS))
    else $error("Parallel value not captured on latch rise.");

  a_serial_load_move: assert property (s_load_rise |=> fb_q == $past(shift_q[FB_LSB +: FB_WIDTH]) && obs_q == $past(shift_q[OBS_LSB +: OBS_WIDTH]))
    else $error("Shift contents not moved on serial load rise.");

  a_serial_freeze: assert property (s_serial_idle ##0 !SERIAL_LOAD |=> $stable(fb_q) && $stable(out_code_q))
    else $error("Divide values moved while serial load low.");

  a_follow_shift: assert property (s_serial_idle ##0 SERIAL_LOAD && sclk_rise |=> fb_q == shift_q[FB_LSB +: FB_WIDTH])
    else $error("Dividers did not follow the shift register.");

  a_observe_data: assert property (CE && serial_mode && obs_q == OBS_SDATA |=> OBSERVE_OUT == $past(SERIAL_DATA))
    else $error("Observe output does not echo serial data.");
endmodule : synth_divider_config_logic

/* partner_ctrl.sv */
// Model of the controller that drives the serial programming pins.
`timescale 1ns/1ns
module partner_ctrl
(
  // Clock.
  input wire logic clk_sys,
  // Serial programming pins.
  output logic serial_clock,
  output logic serial_data,
  output logic serial_load
);
  // The pins are pulled down, so every released line rests low.
  initial
  begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    serial_load = 1'b0;
  end
  // Levels are held two cycles because the block samples pins on its own clock.
  task automatic hold2();
    repeat (2) @(posedge clk_sys);
  endtask : hold2
  task automatic shift_word(input logic [12:0] w);
    for (int i = 12; i >= 0; i--)
    begin
      serial_data <= w[i];
      serial_clock <= 1'b0;
      hold2();
      serial_clock <= 1'b1;
      hold2();
    end
    serial_clock <= 1'b0;
    serial_data <= 1'b0;
    hold2();
  endtask : shift_word
  task automatic set_load(input logic level);
    serial_load <= level;
    hold2();
  endtask : set_load
  task automatic pulse_load();
    serial_load <= 1'b1;
    hold2();
    serial_load <= 1'b0;
    hold2();
  endtask : pulse_load
endmodule : partner_ctrl

/* tb.sv */
// Self-checking testbench for the synthesizer configuration logic.
`timescale 1ns/1ns
module tb;
  import synth_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_WIDTH-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, fbclk, q0, q0oe, q1, q1oe, obs, sclk, sdata, sload;
  logic mr = 1'b0;
  logic latch_n = 1'b0;
  logic [8:0] fb_pins = 9'h000;
  logic [1:0] code_pins = 2'h0;
  logic ref_sel = 1'b1;
  logic pll_sel = 1'b1;
  logic xtal = 1'b0;
  logic vco = 1'b0;
  logic oe0 = 1'b1;
  logic oe1 = 1'b1;
  logic [8:0] fbv;
  logic pref, xdrv;
  logic alt = 1'b0;
  logic alt_on = 1'b0;
  int n_errors = 0;
  int total_checks = 0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) vco <= ~vco;
  always @(posedge vco) xtal <= ~xtal;
  // The alternate reference rests low until a scenario asks it to run, so a wrong source pick shows.
  always @(posedge clk_sys) alt <= alt_on & ~alt;
  partner_ctrl pc (.clk_sys(clk_sys), .serial_clock(sclk), .serial_data(sdata), .serial_load(sload));
  synth_divider_config_logic dut (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DIVIDER_MASTER_RESET(mr), .PARALLEL_LATCH_N(latch_n), .FEEDBACK_DIVIDE_PINS(fb_pins),
    .OUTPUT_DIVIDE_PINS(code_pins), .SERIAL_CLOCK(sclk), .SERIAL_DATA(sdata), .SERIAL_LOAD(sload),
    .REFERENCE_SOURCE_SELECT(ref_sel), .CRYSTAL_INPUT(xtal), .ALTERNATE_REFERENCE(alt),
    .PLL_BYPASS_SELECT(pll_sel), .VCO_CLOCK(vco), .CRYSTAL_DRIVE(xdrv), .PLL_REFERENCE(pref),
    .FEEDBACK_VALUE(fbv), .FEEDBACK_CLOCK(fbclk), .OUTPUT_ZERO_ENABLE(oe0), .OUTPUT_ONE_ENABLE(oe1),
    .CLOCK_OUT_ZERO(q0), .CLOCK_OUT_ZERO_OE(q0oe), .CLOCK_OUT_ONE(q1), .CLOCK_OUT_ONE_OE(q1oe),
    .OBSERVE_OUT(obs));
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang();
    n_errors++;
    test_done();
  endtask : hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic stat(input logic [8:0] f, input logic [1:0] c, input logic [1:0] o, input logic s,
                      input logic m);
    logic [31:0] v;
    logic e;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, STATUS_OFFSET, 32'h00000000, v, e);
    chk(v, {16'h0000, m, (f >= 9'h019 && f <= 9'h01F), s, o, c, f});
  endtask : stat
  // Measures one full high run and the low run after it on the chosen clock.
  task automatic hi_lo(input logic sel, input int exp);
    int n, h, l;
    n = 0;
    h = 0;
    l = 0;
    repeat (30) @(posedge clk_sys);
    while ((sel ? fbclk : q0) !== 1'b0 && n < 300) begin @(posedge clk_sys); n++; end
    while ((sel ? fbclk : q0) !== 1'b1 && n < 300) begin @(posedge clk_sys); n++; end
    while ((sel ? fbclk : q0) === 1'b1 && n < 300) begin @(posedge clk_sys); n++; h++; end
    while ((sel ? fbclk : q0) === 1'b0 && n < 300) begin @(posedge clk_sys); n++; l++; end
    if (n >= 300)
      hang();
    chk(h, exp);
    chk(l, exp);
  endtask : hi_lo
  task automatic s_parallel();
    for (int c = 0; c < 4; c++)
    begin
      fb_pins <= 9'(25 + c);
      code_pins <= 2'(c);
      stat(9'(25 + c), 2'(c), 2'h0, 1'b0, 1'b0);
      chk(fbv, 25 + c);
      chk(obs, 1'b0);
      hi_lo(1'b0, c + 3);
      hi_lo(1'b1, 25 + c);
    end
  endtask : s_parallel
  task automatic s_latch();
    fb_pins <= 9'h01C;
    code_pins <= 2'h1;
    repeat (3) @(posedge clk_sys);
    latch_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    fb_pins <= 9'h01E;
    code_pins <= 2'h2;
    stat(9'h01C, 2'h1, 2'h0, 1'b1, 1'b0);
    latch_n <= 1'b0;
    stat(9'h01E, 2'h2, 2'h0, 1'b0, 1'b0);
  endtask : s_latch
  task automatic s_serial();
    logic prev;
    latch_n <= 1'b1;
    pc.shift_word({2'b01, 2'b11, 9'd26});
    stat(9'h01E, 2'h2, 2'h0, 1'b1, 1'b0);
    pc.pulse_load();
    stat(9'h01A, 2'h3, 2'h1, 1'b1, 1'b0);
    fork
      pc.shift_word({2'b11, 2'b00, 9'd31});
      begin
        @(posedge clk_sys);
        prev = sdata;
        repeat (40)
        begin
          @(posedge clk_sys);
          chk(obs, prev);
          prev = sdata;
        end
      end
    join
    stat(9'h01A, 2'h3, 2'h1, 1'b1, 1'b0);
    pc.pulse_load();
    stat(9'h01F, 2'h0, 2'h3, 1'b1, 1'b0);
  endtask : s_serial
  task automatic s_follow();
    pc.set_load(1'b1);
    pc.shift_word({2'b10, 2'b01, 9'd28});
    stat(9'h01C, 2'h1, 2'h2, 1'b1, 1'b0);
    pc.set_load(1'b0);
    pc.shift_word({2'b11, 2'b00, 9'd31});
    stat(9'h01C, 2'h1, 2'h2, 1'b1, 1'b0);
    pc.pulse_load();
    stat(9'h01F, 2'h0, 2'h3, 1'b1, 1'b0);
  endtask : s_follow
  task automatic s_mreset();
    int bad;
    bad = 0;
    mr <= 1'b1;
    repeat (3) @(posedge clk_sys);
    repeat (40)
    begin
      @(posedge clk_sys);
      bad += (q0 !== 1'b0 || q1 !== 1'b0);
    end
    chk(bad, 0);
    stat(9'h01F, 2'h0, 2'h3, 1'b1, 1'b1);
    mr <= 1'b0;
    hi_lo(1'b0, 3);
  endtask : s_mreset
  task automatic s_bypass();
    int moves;
    int bad;
    logic pq, px;
    moves = 0;
    bad = 0;
    pll_sel <= 1'b0;
    hi_lo(1'b0, 6);
    ref_sel <= 1'b0;
    repeat (30) @(posedge clk_sys);
    pq = q0;
    px = xtal;
    repeat (40)
    begin
      @(posedge clk_sys);
      moves += (q0 !== pq);
      bad += (pref !== 1'b0 || xdrv !== ~px);
      pq = q0;
      px = xtal;
    end
    chk(moves, 0);
    chk(bad, 0);
    alt_on <= 1'b1;
    hi_lo(1'b0, 3);
    alt_on <= 1'b0;
    ref_sel <= 1'b1;
    pll_sel <= 1'b1;
  endtask : s_bypass
  task automatic s_oe();
    for (int i = 0; i < 4; i++)
    begin
      oe0 <= i[0];
      oe1 <= i[1];
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({q1oe, q0oe}, i[1:0]);
    end
  endtask : s_oe
  task automatic s_apb();
    logic [31:0] v;
    logic e;
    apb(1'b1, CTRL_OFFSET, 32'h00000001, v, e);
    apb(1'b0, CTRL_OFFSET, 32'h00000000, v, e);
    chk(v, 32'h00000001);
    stat(9'h01F, 2'h0, 2'h3, 1'b1, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h00000000, v, e);
    apb(1'b0, 12'h008, 32'h00000000, v, e);
    chk(v, 32'h00000000);
    chk(e, 1'b1);
  endtask : s_apb
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    stat(9'h000, 2'h0, 2'h0, 1'b0, 1'b0);
    s_parallel();
    s_latch();
    s_serial();
    s_follow();
    s_mreset();
    s_bypass();
    s_oe();
    s_apb();
    test_done();
  end
endmodule : tb
